// File: hdl/lnu_defines.svh
// What this block does
// - writing one to soft reset resets controller; bit clears itself when done
// - revision select zero picks enhanced checksum, one picks classic checksum
// - bus mode codes 00/01/10 give both checks, neither, checksum only; no listen
// - bus mode code 11 is listen mode with checksum and time-out active
// - byte mode codes 00/01/10 give 8-bit no, even, odd parity, no listen
// - byte mode code 11 is listen mode, 8-bit, no parity
// - enable bit turns controller off at zero, on at one, in both modes
// - command field only acts while the controller enable is set
// - command 000 waits for header and aborts; 001 sends a header
// - command 010 receives a response; 011 sends a response
// - byte mode: 100 stops both, 11x enables receive, 1x1 enables transmit
// - identifier status reads 0xx normally, 100..111 for ids 0x3c..0x3f
// - busy status reads one while receiving or transmitting
// - error summary sets with any of eight error flags; raises error interrupt if enabled
// - writing one to error summary clears it and all error flags
// - in byte mode a data register read also clears the error summary
// - identifier flag set on slave id present or master header done; irq if enabled
// - in bus mode, after any protocol error the controller returns to command 000
// - receive-done set at response end in bus mode, per character in byte mode
`ifndef LNU_DEFINES_SVH
`define LNU_DEFINES_SVH
`define LNU_ADDR_W         8
`define LNU_OFF_CTRL       8'hc8
`define LNU_OFF_STAT       8'hc9
`define LNU_OFF_IEN        8'hca
`define LNU_OFF_ERR        8'hcb
`define LNU_OFF_BTR        8'hcc
`define LNU_OFF_BRRL       8'hcd
`define LNU_OFF_BRRH       8'hce
`define LNU_OFF_DLR        8'hcf
`define LNU_OFF_IDR        8'hd0
`define LNU_OFF_SEL        8'hd1
`define LNU_OFF_DAT        8'hd2
`define LNU_BTR_RST        8'h20
`define LNU_IDR_RST        8'h80
`define LNU_BRRH_MASK      8'h0f
`define LNU_IEN_MASK       8'h0f
`define LNU_SEL_MASK       8'h0f
`define LNU_BTR_MASK       8'hbf
`define LNU_SWRES_CYC      4'h4
`define LNU_CMD_RXHDR      3'h0
`define LNU_CMD_TXHDR      3'h1
`define LNU_CMD_RXRSP      3'h2
`define LNU_CMD_TXRSP      3'h3
`define LNU_SPECIAL_ID_HI  4'hf
`endif

// File: hdl/lnu_pkg.sv
package lnu_pkg;
   typedef struct packed {
      logic       softReset;
      logic       legacyRevision;
      logic [1:0] configField;
      logic       controllerEnable;
      logic [2:0] commandField;
   } lnu_ctrl_s;

   typedef struct packed {
      logic checksumOn;
      logic timeoutOn;
      logic listenOn;
      logic parityOn;
      logic parityOdd;
      logic classicChecksum;
      logic byteRxOn;
      logic byteTxOn;
   } lnu_mode_s;

   // hardware event strobes from the frame engine
   typedef struct packed {
      logic       idPresent;
      logic       headerSent;
      logic       responseRxDone;
      logic       responseTxDone;
      logic       charRxDone;
      logic       charTxDone;
      logic [7:0] errorSet;
      logic       abortSeen;
      logic       busy;
      logic [5:0] rxIdentifier;
      logic       rxByteValid;
      logic [7:0] rxByte;
   } lnu_event_s;

   typedef enum logic [1:0] {
      LNU_IDLE,
      LNU_RESETTING
   } lnu_rst_e;

   typedef struct packed {
      lnu_ctrl_s  ctrl;
      logic [2:0] idStatus;
      logic       errSum;
      logic       idDone;
      logic       txDone;
      logic       rxDone;
      logic [3:0] irqEn;
      logic [7:0] errFlags;
      logic [7:0] bitTiming;
      logic [7:0] baudLow;
      logic [7:0] baudHigh;
      logic [7:0] dataLengths;
      logic [7:0] frameId;
      logic [7:0] bufSelect;
      logic [7:0] txData;
      logic [7:0] rxData;
      logic       txStart;
      logic       cmdStart;
      logic [7:0] rdData;
      lnu_rst_e   rstState;
      logic [3:0] rstCount;
   } lnu_state_s;
endpackage

// File: hdl/lnu_mode_decode.sv
`timescale 1ns/1ps
`include "lnu_defines.svh"
// turns the control register into mode flags for the frame engine
module lnu_mode_decode
(
   input  wire lnu_pkg::lnu_ctrl_s ctrl,
   input  wire logic               byteMode,
   output lnu_pkg::lnu_mode_s      mode
);
   always_comb
   begin
      mode                 = '0;
      mode.classicChecksum = ctrl.legacyRevision;
      if (!byteMode)
      begin
         // code 11 keeps both checks, like 00, but only listens
         mode.checksumOn = (ctrl.configField != 2'h1);
         mode.timeoutOn  = (ctrl.configField == 2'h0) || (ctrl.configField == 2'h3);
         mode.listenOn   = (ctrl.configField == 2'h3);
      end
      else
      begin
         mode.parityOn  = (ctrl.configField == 2'h1) || (ctrl.configField == 2'h2);
         mode.parityOdd = (ctrl.configField == 2'h2);
         mode.listenOn  = (ctrl.configField == 2'h3);
         // gated by enable: codes only act on an enabled controller
         mode.byteRxOn  = ctrl.controllerEnable && (ctrl.commandField[2:1] == 2'h3);
         mode.byteTxOn  = ctrl.controllerEnable && ctrl.commandField[2]
                          && ctrl.commandField[0];
      end
   end
endmodule // lnu_mode_decode

// File: hdl/lnu_control_status.sv
`timescale 1ns/1ps
`include "lnu_defines.svh"
// control and status registers of the bus/byte serial controller
module lnu_control_status
(
   input  wire logic                      mclk,
   input  wire logic                      rst_b,
   input  wire logic [`LNU_ADDR_W-1:0]    regAddr,
   input  wire logic [7:0]                regWrData,
   input  wire logic                      regWrite,
   input  wire logic                      regRead,
   output logic [7:0]                     regRdData,
   input  wire lnu_pkg::lnu_event_s       evt,
   output lnu_pkg::lnu_mode_s             mode,
   output logic                           coreEnable,
   output logic                           coreReset,
   output logic [2:0]                     coreCommand,
   output logic                           cmdStrobe,
   output logic                           txStart,
   output logic [7:0]                     txData,
   output logic [11:0]                    baudDivider,
   output logic [7:0]                     bitTimingOut,
   output logic [7:0]                     dataLengthsOut,
   output logic [7:0]                     frameIdOut,
   output logic [7:0]                     bufSelectOut,
   output logic                           errIrq,
   output logic                           idIrq,
   output logic                           txIrq,
   output logic                           rxIrq
);
   lnu_pkg::lnu_state_s stateQ;
   lnu_pkg::lnu_state_s stateD;
   logic                byteMode;
   logic                wrCtrl;
   logic                wrStat;
   logic                rdDat;
   logic                wrDat;
   logic                anyError;
   logic [5:0]          seenId;

   // byte mode is selected by the top command bit
   assign byteMode = stateQ.ctrl.commandField[2];

   lnu_mode_decode uModeDecode
   (
      .ctrl     (stateQ.ctrl),
      .byteMode (byteMode),
      .mode     (mode)
   );

   function automatic logic hit(input logic [`LNU_ADDR_W-1:0] a,
                                input logic [`LNU_ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   assign wrCtrl   = regWrite && hit(regAddr, `LNU_OFF_CTRL);
   assign wrStat   = regWrite && hit(regAddr, `LNU_OFF_STAT);
   assign rdDat    = regRead && hit(regAddr, `LNU_OFF_DAT);
   assign wrDat    = regWrite && hit(regAddr, `LNU_OFF_DAT);
   assign anyError = |evt.errorSet;
   // a master header carries our own identifier, not a received one
   assign seenId   = evt.idPresent ? evt.rxIdentifier : stateQ.frameId[5:0];

   // next-state logic for all registers
   always_comb
   begin
      stateD         = stateQ;
      stateD.txStart = 1'b0;
      stateD.cmdStart = 1'b0;
      stateD.rdData  = 8'h00;

      // software writes to plain registers
      if (regWrite)
      begin
         case (regAddr)
            `LNU_OFF_CTRL:
            begin
               stateD.ctrl = lnu_pkg::lnu_ctrl_s'(regWrData);
               // writing zero to soft reset does nothing while one is pending
               stateD.ctrl.softReset = stateQ.ctrl.softReset | regWrData[7];
               // the command only goes out with the enable set; dropped during soft reset
               stateD.cmdStart = regWrData[3] && !coreReset;
            end
            `LNU_OFF_IEN:  stateD.irqEn       = regWrData[3:0];
            `LNU_OFF_BTR:  stateD.bitTiming   = regWrData & `LNU_BTR_MASK;
            `LNU_OFF_BRRL: stateD.baudLow     = regWrData;
            `LNU_OFF_BRRH: stateD.baudHigh    = regWrData & `LNU_BRRH_MASK;
            `LNU_OFF_DLR:  stateD.dataLengths = regWrData;
            `LNU_OFF_IDR:  stateD.frameId     = {stateQ.frameId[7:6], regWrData[5:0]};
            `LNU_OFF_SEL:  stateD.bufSelect   = regWrData & `LNU_SEL_MASK;
            `LNU_OFF_DAT:
            begin
               stateD.txData  = regWrData;
               stateD.txStart = stateQ.ctrl.controllerEnable;
            end
            default: ;
         endcase
      end

      // write-one-to-clear flags; sets below override these clears
      if (wrStat && regWrData[3])
      begin
         stateD.errSum   = 1'b0;
         stateD.errFlags = 8'h00;
      end
      if (wrStat && regWrData[2])
         stateD.idDone = 1'b0;
      if (wrStat && regWrData[1])
         stateD.txDone = 1'b0;
      if (wrStat && regWrData[0])
         stateD.rxDone = 1'b0;
      if (byteMode && rdDat)
      begin
         stateD.errSum = 1'b0;
         stateD.rxDone = 1'b0;
      end
      if (byteMode && wrDat)
         stateD.txDone = 1'b0;

      // hardware events; set wins over a same-cycle clear
      if (stateQ.ctrl.controllerEnable)
      begin
         stateD.errFlags = stateD.errFlags | evt.errorSet;
         if (evt.abortSeen)
            stateD.errFlags[7] = 1'b1;
         // summary rises with any flag and falls only on a clear, so a byte-mode
         // data read can leave flags standing behind a cleared summary
         if (anyError || evt.abortSeen)
            stateD.errSum = 1'b1;
         if (evt.idPresent || evt.headerSent)
         begin
            stateD.idDone = 1'b1;
            if (seenId[5:2] == `LNU_SPECIAL_ID_HI)
               stateD.idStatus = {1'b1, seenId[1:0]};
            else
               stateD.idStatus = 3'h0;
         end
         if ((!byteMode && evt.responseRxDone) || (byteMode && evt.charRxDone))
            stateD.rxDone = 1'b1;
         if ((!byteMode && evt.responseTxDone) || (byteMode && evt.charTxDone))
            stateD.txDone = 1'b1;
         if (evt.rxByteValid)
            stateD.rxData = evt.rxByte;
         // protocol error drops back to the withdrawal command
         if (anyError && !byteMode)
            stateD.ctrl.commandField = `LNU_CMD_RXHDR;
      end

      // self-clearing soft reset sequence
      case (stateQ.rstState)
         lnu_pkg::LNU_IDLE:
         begin
            if (stateD.ctrl.softReset)
            begin
               stateD.rstState = lnu_pkg::LNU_RESETTING;
               stateD.rstCount = `LNU_SWRES_CYC;
            end
         end
         lnu_pkg::LNU_RESETTING:
         begin
            if (stateQ.rstCount == 4'h0)
            begin
               // control, status and error flags return to reset values, bit timing and identifier too
               stateD.ctrl        = '0;
               stateD.idStatus    = 3'h0;
               stateD.errSum      = 1'b0;
               stateD.idDone      = 1'b0;
               stateD.txDone      = 1'b0;
               stateD.rxDone      = 1'b0;
               stateD.errFlags    = 8'h00;
               stateD.bitTiming   = `LNU_BTR_RST;
               stateD.frameId     = `LNU_IDR_RST;
               stateD.rstState    = lnu_pkg::LNU_IDLE;
            end
            else
               stateD.rstCount = stateQ.rstCount - 4'h1;
         end
         default: stateD.rstState = lnu_pkg::LNU_IDLE;
      endcase

      // read mux, data valid one cycle later
      if (regRead)
      begin
         case (regAddr)
            `LNU_OFF_CTRL: stateD.rdData = stateQ.ctrl;
            `LNU_OFF_STAT: stateD.rdData = {stateQ.idStatus, evt.busy,
                                            stateQ.errSum, stateQ.idDone,
                                            stateQ.txDone, stateQ.rxDone};
            `LNU_OFF_IEN:  stateD.rdData = {4'h0, stateQ.irqEn};
            `LNU_OFF_ERR:  stateD.rdData = stateQ.errFlags;
            `LNU_OFF_BTR:  stateD.rdData = stateQ.bitTiming;
            `LNU_OFF_BRRL: stateD.rdData = stateQ.baudLow;
            `LNU_OFF_BRRH: stateD.rdData = stateQ.baudHigh;
            `LNU_OFF_DLR:  stateD.rdData = stateQ.dataLengths;
            `LNU_OFF_IDR:  stateD.rdData = stateQ.frameId;
            `LNU_OFF_SEL:  stateD.rdData = stateQ.bufSelect;
            `LNU_OFF_DAT:  stateD.rdData = stateQ.rxData;
            default:       stateD.rdData = 8'h00;
         endcase
      end
   end

   // single state register
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stateQ           <= '0;
         stateQ.bitTiming <= `LNU_BTR_RST;
         stateQ.frameId   <= `LNU_IDR_RST;
         stateQ.rstState  <= lnu_pkg::LNU_IDLE;
      end
      else
         stateQ <= stateD;
   end

   // outputs to the frame engine
   assign regRdData      = stateQ.rdData;
   assign coreEnable     = stateQ.ctrl.controllerEnable;
   assign coreReset      = (stateQ.rstState == lnu_pkg::LNU_RESETTING);
   assign coreCommand    = stateQ.ctrl.commandField;
   // a command write only starts something on an enabled controller
   assign cmdStrobe      = stateQ.cmdStart;
   assign txStart        = stateQ.txStart;
   assign txData         = stateQ.txData;
   assign baudDivider    = {stateQ.baudHigh[3:0], stateQ.baudLow};
   assign bitTimingOut   = stateQ.bitTiming;
   assign dataLengthsOut = stateQ.dataLengths;
   assign frameIdOut     = stateQ.frameId;
   assign bufSelectOut   = stateQ.bufSelect;
   assign errIrq         = stateQ.errSum && stateQ.irqEn[3];
   assign idIrq          = stateQ.idDone && stateQ.irqEn[2];
   assign txIrq          = stateQ.txDone && stateQ.irqEn[1];
   assign rxIrq          = stateQ.rxDone && stateQ.irqEn[0];
endmodule // lnu_control_status

// File: tb/lnu_control_status_monitor.sv
`timescale 1ns/1ps
`include "lnu_defines.svh"
// register-port relations of the control and status block
module lnu_control_status_monitor
(
   input wire logic                   mclk,
   input wire logic                   rst_b,
   input wire logic [`LNU_ADDR_W-1:0] regAddr,
   input wire logic [7:0]             regWrData,
   input wire logic                   regWrite,
   input wire logic                   regRead,
   input wire logic [7:0]             regRdData,
   input wire lnu_pkg::lnu_event_s    evt,
   input wire logic                   coreEnable,
   input wire logic                   coreReset,
   input wire logic [2:0]             coreCommand,
   input wire logic                   txStart,
   input wire logic                   cmdStrobe,
   input wire logic                   errIrq,
   input wire logic                   idIrq
);
   // writes inside a soft reset are left out, the block may drop them
   wire wCtl = regWrite && regAddr == `LNU_OFF_CTRL && !coreReset;
   wire wSt  = regWrite && regAddr == `LNU_OFF_STAT;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   a_enable_follow: assert property (
      wCtl && !regWrData[7] |=> coreEnable == $past(regWrData[3])) else $error("enable wrong");
   a_no_start_off: assert property (
      regWrite && regAddr == `LNU_OFF_DAT && !coreEnable |=> !txStart) else $error("tx start");
   a_cmd_strobe: assert property (
      cmdStrobe == $past(wCtl && regWrData[3])) else $error("command strobe wrong");
   a_reset_bound: assert property (
      $rose(coreReset) |-> ##[1:8] !coreReset) else $error("soft reset too long");
   a_reset_clean: assert property (
      $fell(coreReset) |-> ##[0:2] (!coreEnable && coreCommand == 3'h0)) else $error("reset left");
   a_err_clear: assert property (
      wSt && regWrData[3] && evt.errorSet == 8'h0 && !evt.abortSeen |=> !errIrq)
      else $error("error not cleared");
   a_id_clear: assert property (
      wSt && regWrData[2] && !evt.idPresent && !evt.headerSent |=> !idIrq)
      else $error("id flag not cleared");
   a_set_wins: assert property (
      wSt && regWrData[2] && idIrq && coreEnable && evt.idPresent |=> idIrq)
      else $error("set lost to clear");
   a_abort_cmd: assert property (
      evt.errorSet != 8'h0 && coreEnable && !coreCommand[2] && !regWrite
      |=> ##[0:1] coreCommand == 3'h0) else $error("no withdrawal");
   a_read_idle: assert property (
      !regRead |=> regRdData == 8'h0) else $error("read data outside slot");
endmodule // lnu_control_status_monitor

bind lnu_control_status lnu_control_status_monitor lnu_control_status_monitor_inst (.mclk,
   .rst_b, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .evt, .coreEnable,
   .coreReset, .coreCommand, .txStart, .cmdStrobe, .errIrq, .idIrq);

// File: tb/lnu_engine_model.sv
`timescale 1ns/1ps
`include "lnu_defines.svh"
// frame engine stand-in: bench kicks become one-cycle event strobes, except kick op 4, which sets the busy level
module lnu_engine_model
(
   input  wire logic           mclk,
   input  wire logic           rst_b,
   input  wire logic           coreEnable,
   input  wire logic [2:0]     coreCommand,
   input  wire logic [2:0]     kickOp,
   input  wire logic [7:0]     kickVal,
   output lnu_pkg::lnu_event_s evt
);
   logic hdr_q;
   logic busy_q;
   // header goes out once per tx header command
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hdr_q  <= 1'b0;
         busy_q <= 1'b0;
      end
      else
      begin
         hdr_q <= coreEnable && coreCommand == `LNU_CMD_TXHDR;
         if (kickOp == 3'h4)
            busy_q <= kickVal[0];
      end
   end
   // data lines show the inverse when not valid, never a stale copy
   always_comb
   begin
      evt = '0;
      evt.headerSent = coreEnable && coreCommand == `LNU_CMD_TXHDR && !hdr_q;
      evt.busy = busy_q;
      evt.idPresent = kickOp == 3'h1;
      evt.rxIdentifier = evt.idPresent ? kickVal[5:0] : ~kickVal[5:0];
      evt.errorSet = kickOp == 3'h2 ? kickVal : 8'h0;
      evt.charRxDone = kickOp == 3'h3;
      evt.responseRxDone = kickOp == 3'h3;
      evt.charTxDone = kickOp == 3'h6;
      evt.responseTxDone = kickOp == 3'h6;
      evt.abortSeen = kickOp == 3'h5;
      evt.rxByteValid = kickOp == 3'h3;
      evt.rxByte = evt.rxByteValid ? kickVal : ~kickVal;
   end
endmodule // lnu_engine_model

// File: tb/lin_uart_control_status_tb.sv
`timescale 1ns/1ps
`include "lnu_defines.svh"
// bench for the control and status registers
module lin_uart_control_status_tb;
   logic                   mclk, rst_b, regWrite, regRead, coreEnable, coreReset, txStart;
   logic                   errIrq, idIrq, txIrq, rxIrq, cmdStrobe;
   logic [`LNU_ADDR_W-1:0] regAddr;
   logic [7:0]             regWrData, regRdData, txData, bitTimingOut, dataLengthsOut;
   logic [7:0]             frameIdOut, bufSelectOut, kickVal;
   logic [2:0]             coreCommand, kickOp;
   logic [11:0]            baudDivider;
   lnu_pkg::lnu_event_s    evt;
   lnu_pkg::lnu_mode_s     mode;
   int                     err_total, check_count, w, tq, ev;
   int                     txQ[$];
   logic [7:0]             rwA[6] = '{8'hca, 8'hcc, 8'hcd, 8'hce, 8'hcf, 8'hd1};
   logic [7:0]             rwM[6] = '{8'h0f, 8'hbf, 8'hff, 8'h0f, 8'hff, 8'h0f};
   logic [7:0]             v[6];
   lnu_control_status lnu_control_status_inst (.mclk, .rst_b, .regAddr, .regWrData, .regWrite,
      .regRead, .regRdData, .evt, .mode, .coreEnable, .coreReset, .coreCommand, .cmdStrobe,
      .txStart, .txData, .baudDivider, .bitTimingOut, .dataLengthsOut, .frameIdOut,
      .bufSelectOut, .errIrq, .idIrq, .txIrq, .rxIrq);
   lnu_engine_model lnu_engine_model_inst (.mclk, .rst_b, .coreEnable, .coreCommand, .kickOp,
      .kickVal, .evt);
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
      @(posedge mclk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge mclk);
      regRead <= 1'b0;
      #1 chk(regRdData & m, e);
   endtask
   task automatic kick(input logic [2:0] op, input logic [7:0] d);
      @(posedge mclk);
      kickOp <= op;
      kickVal <= d;
      @(posedge mclk);
      kickOp <= 3'h0;
   endtask
   task automatic test_done();
      $display("checks=%0d errors=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // every transmit pulse must carry the oldest enabled data write
   // looked at on the falling edge, where the pulse has settled
   always @(negedge mclk)
      if (txStart === 1'b1)
      begin
         tq = txQ.size() ? txQ.pop_front() : -1;
         chk(txData, tq);
      end
   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // the sequence needs about 200 cycles
   initial
   begin
      #200000;
      err_total++;
      test_done();
   end
   initial
   begin
      {rst_b, regWrite, regRead, regAddr, regWrData, kickOp, kickVal} = '0;
      w = $urandom(32'h6b298105);
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      for (int a = 8'hc6; a < 8'hd5; a++)
         rdc(8'(a), a == 8'hcc ? 8'h20 : a == 8'hd0 ? 8'h80 : 8'h0);
      for (int i = 0; i < 6; i++)
      begin
         v[i] = 8'($urandom);
         wr(rwA[i], v[i]);
         rdc(rwA[i], v[i] & rwM[i]);
      end
      chk(baudDivider, {v[3][3:0], v[2]});
      chk(bitTimingOut, v[1] & 8'hbf);
      chk(dataLengthsOut, v[4]);
      chk(bufSelectOut, v[5] & 8'h0f);
      for (int m = 0; m < 2; m++)
         for (int c = 0; c < 4; c++)
         begin
            wr(`LNU_OFF_CTRL, {1'b0, c[0], c[1:0], 1'b1, m[0], c[1:0]});
            #1 chk(mode.classicChecksum, c[0]);
            chk(cmdStrobe, 1'b1);
            chk({coreEnable, coreCommand}, 8 + m * 4 + c);
            chk(mode.listenOn, c == 3);
            if (m == 0)
               chk({mode.checksumOn, mode.timeoutOn}, {c != 1, c == 0 || c == 3});
            else
               chk({mode.parityOn, mode.parityOdd}, {c == 1 || c == 2, c == 2});
            if (m == 1)
               chk({mode.byteRxOn, mode.byteTxOn}, c);
            if (m == 0 && c == 1)
               rdc(`LNU_OFF_STAT, 8'h04);
         end
      wr(`LNU_OFF_CTRL, 8'h00);
      #1 chk(cmdStrobe, 1'b0);
      wr(`LNU_OFF_STAT, 8'h0f);
      kick(3'h1, 8'h3c);
      wr(`LNU_OFF_DAT, 8'h55);
      rdc(`LNU_OFF_STAT, 8'h00);
      wr(`LNU_OFF_IEN, 8'h0f);
      wr(`LNU_OFF_CTRL, 8'h08);
      for (int i = 0; i < 5; i++)
      begin
         ev = i == 4 ? 8'h12 : 8'h3c + i;
         kick(3'h1, 8'(ev));
         rdc(`LNU_OFF_STAT, i == 4 ? 8'h04 : 8'(((4 + i) << 5) + 4), i == 4 ? 8'h84 : 8'hff);
         chk(idIrq, 1'b1);
      end
      wr(`LNU_OFF_STAT, 8'h00);
      rdc(`LNU_OFF_STAT, 8'h04, 8'h04);
      fork
         kick(3'h1, 8'h3d);
         wr(`LNU_OFF_STAT, 8'h04);
      join
      rdc(`LNU_OFF_STAT, 8'h04, 8'h04);
      wr(`LNU_OFF_STAT, 8'h04);
      rdc(`LNU_OFF_STAT, 8'h00, 8'h04);
      wr(`LNU_OFF_CTRL, 8'h0a);
      kick(3'h2, 8'h05);
      rdc(`LNU_OFF_ERR, 8'h05);
      rdc(`LNU_OFF_STAT, 8'h08, 8'h08);
      chk({errIrq, coreCommand}, 4'h8);
      rdc(`LNU_OFF_CTRL, 8'h08);
      wr(`LNU_OFF_STAT, 8'h00);
      rdc(`LNU_OFF_ERR, 8'h05);
      wr(`LNU_OFF_STAT, 8'h08);
      rdc(`LNU_OFF_ERR, 8'h00);
      kick(3'h3, 8'h11);
      rdc(`LNU_OFF_STAT, 8'h01, 8'h01);
      wr(`LNU_OFF_IEN, 8'h07);
      kick(3'h5, 8'h00);
      rdc(`LNU_OFF_STAT, 8'h08, 8'h08);
      chk(errIrq, 1'b0);
      rdc(`LNU_OFF_ERR, 8'h80);
      wr(`LNU_OFF_CTRL, 8'h0f);
      kick(3'h3, 8'ha5);
      rdc(`LNU_OFF_STAT, 8'h09, 8'h09);
      chk(rxIrq, 1'b1);
      rdc(`LNU_OFF_DAT, 8'ha5);
      rdc(`LNU_OFF_STAT, 8'h00, 8'h08);
      kick(3'h4, 8'h01);
      rdc(`LNU_OFF_STAT, 8'h10, 8'h10);
      kick(3'h4, 8'h00);
      rdc(`LNU_OFF_STAT, 8'h00, 8'h10);
      kick(3'h6, 8'h00);
      #1 chk({txIrq, rxIrq}, 2'h2);
      for (int i = 0; i < 3; i++)
      begin
         w = $urandom;
         txQ.push_back(w & 255);
         wr(`LNU_OFF_DAT, 8'(w));
      end
      rdc(`LNU_OFF_STAT, 8'h00, 8'h02);
      wr(`LNU_OFF_CTRL, 8'h8f);
      #1 for (w = 0; w < 20 && coreReset !== 1'b1; w++) @(posedge mclk);
      for (w = 0; w < 20 && coreReset === 1'b1; w++) @(posedge mclk);
      rdc(`LNU_OFF_CTRL, 8'h00);
      rdc(`LNU_OFF_BTR, 8'h20);
      chk({coreEnable, txQ.size() == 0}, 2'h1);
      test_done();
   end
endmodule // lin_uart_control_status_tb
